// ---- rtl/sfc_pkg.sv ----
// package for the serial fifo control and status block
package sfc_pkg;
    localparam int DEPTH      = 16;
    localparam int CNT_W      = 5;
    localparam int PTR_W      = 4;
    localparam int ADDR_W     = 4;

    // register indices (byte address = index times four)
    localparam logic [ADDR_W-1:0] REG_FIFO_CONTROL    = 4'h0;
    localparam logic [ADDR_W-1:0] REG_FIFO_FILL_COUNT = 4'h1;
    localparam logic [ADDR_W-1:0] REG_FIFO_STAGE_ERR  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_TX_FIFO_DATA    = 4'h3;
    localparam logic [ADDR_W-1:0] REG_RX_FIFO_DATA    = 4'h4;
    localparam logic [ADDR_W-1:0] REG_SERIAL_STATUS   = 4'h5;

    localparam logic [7:0]  FIFO_CONTROL_RESET = 8'h00;
    localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000;

    // fill count field positions
    localparam int TX_CNT_LSB = 8;
    localparam int RX_CNT_LSB = 0;

    // status bit positions, and the error bit of the receive data read
    localparam int ST_RX_FULL  = 0;
    localparam int ST_TX_EMPTY = 1;
    localparam int ST_RX_ERR   = 2;
    localparam int ST_CTS      = 3;
    localparam int RXD_ERR_BIT = 8;

    localparam logic [CNT_W-1:0] FULL_COUNT = 5'h10;
    localparam logic [CNT_W-1:0] RX_TRIG_0 = 5'h01;
    localparam logic [CNT_W-1:0] RX_TRIG_1 = 5'h04;
    localparam logic [CNT_W-1:0] RX_TRIG_2 = 5'h08;
    localparam logic [CNT_W-1:0] RX_TRIG_3 = 5'h0e;
    localparam logic [CNT_W-1:0] TX_TRIG_0 = 5'h08;
    localparam logic [CNT_W-1:0] TX_TRIG_1 = 5'h04;
    localparam logic [CNT_W-1:0] TX_TRIG_2 = 5'h02;
    localparam logic [CNT_W-1:0] TX_TRIG_3 = 5'h01;

    typedef struct packed {
        logic [1:0] rx_trigger_sel;
        logic [1:0] tx_trigger_sel;
        logic       modem_ctrl_enable;
        logic       tx_fifo_flush;
        logic       rx_fifo_flush;
        logic       loopback;
    } sfc_ctrl_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } sfc_bus_s;

    // received character from the shift logic: data plus parity/framing error
    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] data;
    } sfc_rx_char_s;
endpackage

// ---- rtl/sfc_top.sv ----
// fifo management of the serial port: triggers, flushes, counts, modem gating, loopback, stage errors
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sfc_top
    import sfc_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rstn,
    input  wire sfc_pkg::sfc_bus_s       bus,
    output logic [31:0]                  rdata,
    input  wire logic                    module_standby,
    input  wire logic                    standby_mode,
    input  wire sfc_pkg::sfc_rx_char_s   rx_char,
    input  wire logic                    tx_take,
    output logic [7:0]                   tx_char,
    output logic                         tx_char_valid,
    input  wire logic                    txd_shift,
    input  wire logic                    rxd_pin,
    output logic                         txd_pin,
    output logic                         rxd_shift,
    input  wire logic                    cts_n_pin,
    input  wire logic                    rts_n_req,
    output logic                         cts_n_eff,
    output logic                         rts_n_pin,
    output logic                         rx_full_flag,
    output logic                         tx_empty_flag
);
    import sfc_pkg::*;

    function automatic logic [CNT_W-1:0] rx_trig(input logic [1:0] sel);
        case (sel)
            2'h0:    rx_trig = RX_TRIG_0;
            2'h1:    rx_trig = RX_TRIG_1;
            2'h2:    rx_trig = RX_TRIG_2;
            default: rx_trig = RX_TRIG_3;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] tx_trig(input logic [1:0] sel);
        case (sel)
            2'h0:    tx_trig = TX_TRIG_0;
            2'h1:    tx_trig = TX_TRIG_1;
            2'h2:    tx_trig = TX_TRIG_2;
            default: tx_trig = TX_TRIG_3;
        endcase
    endfunction

    // one decode helper for every register strobe, so pushes, pops and writes agree on addresses
    function automatic logic reg_hit(input logic              strobe,
                                     input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] index);
        reg_hit = strobe && addr == index;
    endfunction

    // a push and a pop in one cycle cancel and leave the count alone
    function automatic logic [CNT_W-1:0] count_step(input logic [CNT_W-1:0] count,
                                                    input logic push, input logic pop);
        count_step = count + CNT_W'(push) - CNT_W'(pop);
    endfunction

    sfc_ctrl_s          fifo_control;
    sfc_ctrl_s          next_fifo_control;
    logic [7:0]         tx_mem [DEPTH];
    logic [7:0]         rx_mem [DEPTH];
    logic [PTR_W-1:0]   tx_rd_ptr;
    logic [PTR_W-1:0]   tx_wr_ptr;
    logic [PTR_W-1:0]   rx_rd_ptr;
    logic [PTR_W-1:0]   rx_wr_ptr;
    logic [PTR_W-1:0]   next_tx_rd_ptr;
    logic [PTR_W-1:0]   next_tx_wr_ptr;
    logic [PTR_W-1:0]   next_rx_rd_ptr;
    logic [PTR_W-1:0]   next_rx_wr_ptr;
    logic [CNT_W-1:0]   tx_count;
    logic [CNT_W-1:0]   rx_count;
    logic [CNT_W-1:0]   next_tx_count;
    logic [CNT_W-1:0]   next_rx_count;
    logic [DEPTH-1:0]   stage_error_flags, next_stage_error_flags;
    logic [31:0]        next_rdata;
    logic               standby_clr;
    logic               stage_clr;
    logic               tx_push, tx_pop, rx_push, rx_pop;
    logic               tx_flush, rx_flush;
    logic               ctrl_wr, tx_data_wr, rx_data_rd;
    logic [7:0]         next_tx_char;
    logic               next_tx_char_valid;
    logic               next_rx_full_flag;
    logic               next_tx_empty_flag;
    logic               next_txd_pin;
    logic               next_rxd_shift;
    logic               next_cts_n_eff;
    logic               next_rts_n_pin;

    // standby clears the control register and both fifos as reset does, but synchronously
    assign standby_clr = module_standby | standby_mode;
    assign tx_flush    = standby_clr | fifo_control.tx_fifo_flush;
    assign rx_flush    = standby_clr | fifo_control.rx_fifo_flush;
    // standby mode keeps the stage error flags; only module standby and reset clear them all, a pop clears its own stage
    assign stage_clr   = module_standby;

    // strobes decoded once; the bus never waits, so a strobe acts in the cycle it stands
    assign ctrl_wr    = reg_hit(bus.wr, bus.addr, REG_FIFO_CONTROL);
    assign tx_data_wr = reg_hit(bus.wr, bus.addr, REG_TX_FIFO_DATA);
    assign rx_data_rd = reg_hit(bus.rd, bus.addr, REG_RX_FIFO_DATA);

    // a full fifo drops pushes, an empty one ignores pops; neither case is reported
    assign tx_push = tx_data_wr && tx_count != FULL_COUNT;
    assign tx_pop  = tx_take && tx_count != '0;
    assign rx_push = rx_char.valid && rx_count != FULL_COUNT;
    assign rx_pop  = rx_data_rd && rx_count != '0;

    always_comb begin
        next_fifo_control = fifo_control;
        if (standby_clr) begin
            next_fifo_control = sfc_ctrl_s'(FIFO_CONTROL_RESET);
        end else if (ctrl_wr) begin
            next_fifo_control = sfc_ctrl_s'(bus.wdata[7:0]);
        end
    end

    always_comb begin
        next_tx_rd_ptr = tx_rd_ptr;
        next_tx_wr_ptr = tx_wr_ptr;
        next_tx_count  = tx_count;
        if (tx_flush) begin
            next_tx_rd_ptr = '0;
            next_tx_wr_ptr = '0;
            next_tx_count  = '0;
        end else begin
            if (tx_push) begin
                next_tx_wr_ptr = tx_wr_ptr + 1'b1;
            end
            if (tx_pop) begin
                next_tx_rd_ptr = tx_rd_ptr + 1'b1;
            end
            next_tx_count = count_step(tx_count, tx_push, tx_pop);
        end
    end

    always_comb begin
        next_rx_rd_ptr = rx_rd_ptr;
        next_rx_wr_ptr = rx_wr_ptr;
        next_rx_count  = rx_count;
        if (rx_flush) begin
            next_rx_rd_ptr = '0;
            next_rx_wr_ptr = '0;
            next_rx_count  = '0;
        end else begin
            if (rx_push) begin
                next_rx_wr_ptr = rx_wr_ptr + 1'b1;
            end
            if (rx_pop) begin
                next_rx_rd_ptr = rx_rd_ptr + 1'b1;
            end
            next_rx_count = count_step(rx_count, rx_push, rx_pop);
        end
    end

    // flags follow absolute stage positions; flush resets pointers but keeps flags
    always_comb begin
        next_stage_error_flags = stage_error_flags;
        if (stage_clr) begin
            next_stage_error_flags = '0;
        end else begin
            if (rx_pop) begin
                next_stage_error_flags[rx_rd_ptr] = 1'b0;
            end
            // a new erroneous byte into a stage wins over the clear of that stage
            if (rx_push && !rx_flush) begin
                next_stage_error_flags[rx_wr_ptr] = rx_char.err;
            end
        end
    end

    always_comb begin
        next_rdata = UNMAPPED_READ;
        if (bus.rd) begin
            case (bus.addr)
                REG_FIFO_CONTROL: begin
                    next_rdata[7:0] = fifo_control;
                end
                REG_FIFO_FILL_COUNT: begin
                    // unused count bits stay zero from the default
                    next_rdata[TX_CNT_LSB +: CNT_W] = tx_count;
                    next_rdata[RX_CNT_LSB +: CNT_W] = rx_count;
                end
                REG_FIFO_STAGE_ERR: begin
                    next_rdata[DEPTH-1:0] = stage_error_flags;
                end
                REG_RX_FIFO_DATA: begin
                    if (rx_count != '0) begin
                        next_rdata[7:0] = rx_mem[rx_rd_ptr];
                        next_rdata[RXD_ERR_BIT] = stage_error_flags[rx_rd_ptr];
                    end
                end
                REG_SERIAL_STATUS: begin
                    next_rdata[ST_RX_FULL]  = rx_full_flag;
                    next_rdata[ST_TX_EMPTY] = tx_empty_flag;
                    next_rdata[ST_RX_ERR]   = |stage_error_flags;
                    next_rdata[ST_CTS]      = cts_n_eff;
                end
                default: next_rdata = UNMAPPED_READ;
            endcase
        end
    end

    // status flags follow the counts after the same edge
    always_comb begin
        next_rx_full_flag  = next_rx_count >= rx_trig(next_fifo_control.rx_trigger_sel);
        next_tx_empty_flag = next_tx_count <= tx_trig(next_fifo_control.tx_trigger_sel);
    end

    // a byte written into an empty fifo is not in the array yet, so it is bypassed to the head
    always_comb begin
        next_tx_char_valid = next_tx_count != '0;
        if (tx_push && !tx_flush && next_tx_rd_ptr == tx_wr_ptr) begin
            next_tx_char = bus.wdata[7:0];
        end else begin
            next_tx_char = tx_mem[next_tx_rd_ptr];
        end
    end

    always_comb begin
        // line held idle high while looping back, so the partner sees nothing
        next_txd_pin   = next_fifo_control.loopback ? 1'b1 : txd_shift;
        next_rxd_shift = next_fifo_control.loopback ? txd_shift : rxd_pin;
        // modem control off: the far side is taken as always clear to send
        next_cts_n_eff = next_fifo_control.modem_ctrl_enable ? cts_n_pin : 1'b0;
        next_rts_n_pin = next_fifo_control.modem_ctrl_enable ? rts_n_req : 1'b0;
    end

    // standby reaches the reset value through the next-value logic
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fifo_control <= sfc_ctrl_s'(FIFO_CONTROL_RESET);
        end else begin
            fifo_control <= next_fifo_control;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_rd_ptr <= '0;
            tx_wr_ptr <= '0;
            tx_count  <= '0;
        end else begin
            tx_rd_ptr <= next_tx_rd_ptr;
            tx_wr_ptr <= next_tx_wr_ptr;
            tx_count  <= next_tx_count;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_rd_ptr <= '0;
            rx_wr_ptr <= '0;
            rx_count  <= '0;
        end else begin
            rx_rd_ptr <= next_rx_rd_ptr;
            rx_wr_ptr <= next_rx_wr_ptr;
            rx_count  <= next_rx_count;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stage_error_flags <= '0;
        end else begin
            stage_error_flags <= next_stage_error_flags;
        end
    end

    // read data stands for one cycle only and is zero otherwise
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_full_flag  <= 1'b0;
            tx_empty_flag <= 1'b0;
        end else begin
            rx_full_flag  <= next_rx_full_flag;
            tx_empty_flag <= next_tx_empty_flag;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_char       <= '0;
            tx_char_valid <= 1'b0;
        end else begin
            tx_char       <= next_tx_char;
            tx_char_valid <= next_tx_char_valid;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            txd_pin   <= 1'b1;
            rxd_shift <= 1'b1;
            cts_n_eff <= 1'b0;
            rts_n_pin <= 1'b0;
        end else begin
            txd_pin   <= next_txd_pin;
            rxd_shift <= next_rxd_shift;
            cts_n_eff <= next_cts_n_eff;
            rts_n_pin <= next_rts_n_pin;
        end
    end

    // storage needs no reset; counts decide what is valid
    always_ff @(posedge core_clk) begin
        if (tx_push && !tx_flush) begin
            tx_mem[tx_wr_ptr] <= bus.wdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rx_push && !rx_flush) begin
            rx_mem[rx_wr_ptr] <= rx_char.data;
        end
    end
endmodule
`default_nettype wire

// ---- tb/sfc_chk_sva.sv ----
// port checker for the serial fifo control block
`timescale 1ns/10ps
`default_nettype none
module sfc_chk
    import sfc_pkg::*;
(
    input wire logic            core_clk,
    input wire logic            rstn,
    input wire sfc_pkg::sfc_bus_s bus,
    input wire logic [31:0]     rdata,
    input wire logic            module_standby,
    input wire logic            standby_mode,
    input wire logic            txd_shift,
    input wire logic            rxd_pin,
    input wire logic            txd_pin,
    input wire logic            rxd_shift,
    input wire logic            cts_n_pin,
    input wire logic            rts_n_req,
    input wire logic            cts_n_eff,
    input wire logic            rts_n_pin,
    input wire logic            rx_full_flag,
    input wire logic            tx_empty_flag,
    input wire logic            tx_char_valid
);
    logic [7:0] ctl;
    logic [7:0] next_ctl;
    // shadow of the control register, so gating can be judged from the bus alone
    always_comb begin
        next_ctl = ctl;
        if (module_standby || standby_mode) begin
            next_ctl = 8'h00;
        end else if (bus.wr && bus.addr == REG_FIFO_CONTROL) begin
            next_ctl = bus.wdata[7:0];
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctl <= 8'h00;
        end else begin
            ctl <= next_ctl;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence both_flush_held;
        (ctl[2:1] == 2'b11) [*2];
    endsequence
    AST_CTS: assert property (cts_n_eff == (ctl[3] ? $past(cts_n_pin) : 1'b0))
        else $error("cts gating wrong");
    AST_RTS: assert property (rts_n_pin == (ctl[3] ? $past(rts_n_req) : 1'b0))
        else $error("rts gating wrong");
    AST_TXD: assert property ($past(rstn) |-> txd_pin == (ctl[0] ? 1'b1 : $past(txd_shift)))
        else $error("line output wrong");
    AST_RXD: assert property ($past(rstn) |-> rxd_shift == (ctl[0] ? $past(txd_shift) : $past(rxd_pin)))
        else $error("receive input route wrong");
    AST_CTL_RD: assert property ($past(bus.rd && bus.addr == REG_FIFO_CONTROL) |-> rdata == {24'h0, $past(ctl)})
        else $error("control readback wrong");
    AST_CNT_RSVD: assert property ($past(bus.rd && bus.addr == REG_FIFO_FILL_COUNT) |-> rdata[15:13] == 3'h0 && rdata[7:5] == 3'h0)
        else $error("reserved count bits set");
    AST_FLUSH_CNT: assert property (both_flush_held ##0 (bus.rd && bus.addr == REG_FIFO_FILL_COUNT) |=> rdata[15:0] == 16'h0)
        else $error("count not cleared by flushes");
    AST_RX_FLUSH: assert property (ctl[1] [*2] |-> !rx_full_flag)
        else $error("rx flag while flushing");
    AST_TX_FLUSH: assert property (ctl[2] [*2] |-> tx_empty_flag && !tx_char_valid)
        else $error("tx fifo not empty while flushing");
    AST_STBY: assert property ($past(standby_mode || module_standby) |-> !tx_char_valid && !rx_full_flag && tx_empty_flag)
        else $error("fifos not emptied by standby");
    AST_STATUS: assert property ($past(bus.rd && bus.addr == REG_SERIAL_STATUS) |-> rdata[1:0] == {$past(tx_empty_flag), $past(rx_full_flag)})
        else $error("status flags wrong");
endmodule
`default_nettype wire

// ---- tb/sfc_line_model.sv ----
// line side model: serial lines, received characters, transmit consumption
`timescale 1ns/10ps
`default_nettype none
module sfc_line_model
    import sfc_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              tx_char_valid,
    input wire logic              drain,
    output sfc_pkg::sfc_rx_char_s rx_char,
    output logic                  tx_take,
    output logic                  txd_shift,
    output logic                  rxd_pin,
    output logic                  cts_n_pin
);
    logic [4:0] ph = 5'h00;
    initial rx_char = '0;
    initial tx_take = 1'b0;
    // bits move once per 16 core cycles, far inside the external clock limits
    assign txd_shift = ph[4];
    assign rxd_pin = ~ph[4];
    assign cts_n_pin = ph[3];
    // slow consumer: at most one byte every other cycle
    always @(posedge core_clk) begin
        ph <= ph + 5'h01;
        tx_take <= drain && tx_char_valid && !tx_take;
    end
    task automatic send(input logic [7:0] d, input logic e);
        @(posedge core_clk);
        rx_char <= {1'b1, e, d};
        @(posedge core_clk);
        rx_char.valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/sfc_top_tb_top.sv ----
// self-checking testbench for the serial fifo control block
`timescale 1ns/10ps
`default_nettype none
module sfc_top_tb_top;
    import sfc_pkg::*;
    logic core_clk = 1'b0, rstn = 1'b0, module_standby = 1'b0, standby_mode = 1'b0;
    logic rts_n_req = 1'b0, drain = 1'b0, tx_take, txd_shift, rxd_pin, cts_n_pin;
    logic tx_char_valid, txd_pin, rxd_shift, cts_n_eff, rts_n_pin, rx_full_flag, tx_empty_flag;
    logic [7:0] tx_char;
    logic [31:0] rdata;
    sfc_bus_s bus = '0;
    sfc_rx_char_s rx_char;
    int failures = 0, compares = 0, cyc = 0;
    int rt[4] = '{1, 4, 8, 14};
    int tt[4] = '{8, 4, 2, 1};
    sfc_top dut (.core_clk, .rstn, .bus, .rdata, .module_standby, .standby_mode, .rx_char, .tx_take, .tx_char,
        .tx_char_valid, .txd_shift, .rxd_pin, .txd_pin, .rxd_shift, .cts_n_pin, .rts_n_req, .cts_n_eff,
        .rts_n_pin, .rx_full_flag, .tx_empty_flag);
    sfc_line_model u_line (.core_clk, .tx_char_valid, .drain, .rx_char, .tx_take, .txd_shift, .rxd_pin, .cts_n_pin);
    always #4 core_clk = ~core_clk;
    task automatic end_sim();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        rts_n_req <= ~rts_n_req;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge core_clk);
        bus <= '{addr:a, wdata:32'h0, wr:1'b0, rd:1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        rc(REG_FIFO_CONTROL, '1, 0);
        rc(REG_FIFO_FILL_COUNT, '1, 0);
        wr(REG_FIFO_FILL_COUNT, 32'h0);
        rc(REG_FIFO_FILL_COUNT, '1, 0);
        rc(REG_SERIAL_STATUS, 32'h8, 0);
        rc(4'hf, '1, 0);
        wr(REG_FIFO_CONTROL, 32'hf9);
        rc(REG_FIFO_CONTROL, '1, 32'hf9);
        repeat (40) @(posedge core_clk);
        for (int s = 0; s < 4; s++) begin
            wr(REG_FIFO_CONTROL, 32'(s << 6) | 32'h02);
            rc(REG_FIFO_FILL_COUNT, 32'h1f, 0);
            rc(REG_FIFO_STAGE_ERR, 32'hffff, 32'(s > 0 ? 4 : 0));
            wr(REG_FIFO_CONTROL, 32'(s << 6));
            for (int n = 1; n <= 17; n++) begin
                u_line.send(8'(n), n == 3);
                rc(REG_FIFO_FILL_COUNT, 32'h1f, 32'(n > 16 ? 16 : n));
                rc(REG_SERIAL_STATUS, 32'h1, 32'(n >= rt[s]));
            end
            rc(REG_FIFO_STAGE_ERR, 32'hffff, 32'h4);
        end
        for (int n = 1; n <= 16; n++) begin
            rc(REG_RX_FIFO_DATA, 32'h1ff, 32'(n) | (n == 3 ? 32'h100 : 32'h0));
        end
        rc(REG_FIFO_FILL_COUNT, 32'hffff, 0);
        rc(REG_FIFO_STAGE_ERR, 32'hffff, 0);
        for (int s = 0; s < 4; s++) begin
            wr(REG_FIFO_CONTROL, 32'(s << 4) | 32'h04);
            wr(REG_FIFO_CONTROL, 32'(s << 4));
            for (int n = 1; n <= 17; n++) begin
                wr(REG_TX_FIFO_DATA, 32'(n));
                rc(REG_FIFO_FILL_COUNT, 32'h1f00, 32'(n > 16 ? 16 : n) << 8);
                rc(REG_SERIAL_STATUS, 32'h2, 32'(n <= tt[s]) << 1);
            end
        end
        chk({24'h0, tx_char}, 32'h1);
        drain <= 1'b1;
        for (int i = 0; i < 100 && tx_char_valid !== 1'b0; i++) begin
            @(posedge core_clk);
            #1;
        end
        drain <= 1'b0;
        rc(REG_FIFO_FILL_COUNT, 32'h1f00, 0);
        rc(REG_SERIAL_STATUS, 32'h2, 32'h2);
        u_line.send(8'ha5, 1'b1);
        wr(REG_TX_FIFO_DATA, 32'h3c);
        wr(REG_FIFO_CONTROL, 32'h06);
        rc(REG_FIFO_FILL_COUNT, 32'hffff, 0);
        wr(REG_FIFO_CONTROL, 32'hc8);
        u_line.send(8'h5a, 1'b1);
        repeat (40) @(posedge core_clk);
        standby_mode <= 1'b1;
        @(posedge core_clk);
        standby_mode <= 1'b0;
        rc(REG_FIFO_CONTROL, 32'hff, 0);
        rc(REG_FIFO_FILL_COUNT, 32'hffff, 0);
        module_standby <= 1'b1;
        @(posedge core_clk);
        module_standby <= 1'b0;
        rc(REG_FIFO_STAGE_ERR, 32'hffff, 0);
        end_sim();
    end
endmodule
bind sfc_top sfc_chk u_chk (.core_clk, .rstn, .bus, .rdata, .module_standby, .standby_mode, .txd_shift, .rxd_pin,
    .txd_pin, .rxd_shift, .cts_n_pin, .rts_n_req, .cts_n_eff, .rts_n_pin, .rx_full_flag, .tx_empty_flag, .tx_char_valid);
`default_nettype wire
